// ===== hdl/cfg_port_pkg.sv
// constants, mode codes and register map of the configuration load port
// assumes: pclk at 125 MHz, apb with 32-bit data, link clock on a pin
// ============================================================
package cfg_port_pkg;
  // ============================================================
  // timing
  localparam int PCLK_NS = 8;
  localparam int CLEAR_NS = 1000;
  localparam int STARTUP_NS = 400;
  localparam int LEADER_HALF_NS = 64;
  localparam int CLEAR_CYC = (CLEAR_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int STARTUP_CYC = (STARTUP_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int LEADER_HALF_CYC = LEADER_HALF_NS / PCLK_NS;
  localparam int TMR_W = 8;
  // ============================================================
  // mode-select codes
  localparam logic [2:0] MODE_LEADER = 3'h0;
  localparam logic [2:0] MODE_PARALLEL = 3'h6;
  localparam logic [2:0] MODE_FOLLOWER = 3'h7;
  // ============================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LEN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_LAST = 8'h10;
  localparam logic [7:0] ADDR_USER_OUT = 8'h14;
  localparam logic [7:0] ADDR_USER_OE = 8'h18;
  localparam logic [7:0] ADDR_USER_IN = 8'h1c;
  // control fields
  localparam int CTRL_KEEP = 0;
  localparam int CTRL_DONE_OD = 1;
  localparam int CTRL_RESTART = 2;
  // user I/O vector: byte pins, busy/chain pin, clear-status pin
  localparam int UIO_W = 10;
  localparam int UIO_BUSY = 8;
  localparam int UIO_INIT = 9;
  localparam int LEN_W = 16;
  localparam logic [LEN_W-1:0] LEN_RESET = 16'h0010;
  localparam logic [UIO_W-1:0] UIO_RESET = 10'h000;
  typedef enum logic [1:0] {ST_CLEAR, ST_LOAD, ST_START, ST_USER} cfg_state_t;
endpackage : cfg_port_pkg

// ===== hdl/word_toggle_cdc.sv
// one byte carried from the link clock to pclk by a toggle handshake
// assumes: source launches no new byte until busy falls; both sides share presetn
`timescale 1ns/100ps
`default_nettype none
module word_toggle_cdc (
  input wire logic src_clk,
  input wire logic dst_clk,
  input wire logic presetn,
  input wire logic launch,
  input wire logic [7:0] src_data,
  output logic busy,
  output logic dst_valid,
  output logic [7:0] dst_data
);
  logic tog_r, tog_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic ack_m_r, ack_s_r;
  logic req_m_r, req_s_r, req_d_r;
  logic [7:0] out_r, out_nxt;
  logic pulse, valid_r;

  // ============================================================
  // source side
  always_comb begin
    tog_nxt = launch ? ~tog_r : tog_r;
    hold_nxt = launch ? src_data : hold_r;
  end
  always_ff @(posedge src_clk or negedge presetn) begin
    if (!presetn) begin
      tog_r <= 1'b0;
      hold_r <= 8'h00;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end else begin
      tog_r <= tog_nxt;
      hold_r <= hold_nxt;
      ack_m_r <= req_d_r;
      ack_s_r <= ack_m_r;
    end
  end
  assign busy = tog_r ^ ack_s_r;

  // ============================================================
  // destination side; hold_r is stable once the toggle is seen
  assign pulse = req_s_r ^ req_d_r;
  always_comb begin
    out_nxt = pulse ? hold_r : out_r;
  end
  always_ff @(posedge dst_clk or negedge presetn) begin
    if (!presetn) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      req_d_r <= 1'b0;
      out_r <= 8'h00;
      valid_r <= 1'b0;
    end else begin
      valid_r <= pulse;
      req_m_r <= tog_r;
      req_s_r <= req_m_r;
      req_d_r <= req_s_r;
      out_r <= out_nxt;
    end
  end
  // valid and data both leave from flip-flops, in the same cycle
  assign dst_valid = valid_r;
  assign dst_data = out_r;
endmodule : word_toggle_cdc
`default_nettype wire

// ===== hdl/fpga_config_port.sv
// configuration load port: apb registers, sequencer and pin drivers on pclk, link shift and strobe logic on cfg clock
// assumes: pins resolved by the bench from out/oe; loader obeys busy
`timescale 1ns/100ps
`default_nettype none
module fpga_config_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cfg_clock,
  output logic cfg_clock_out,
  output logic cfg_clock_oe,
  input wire logic restart_n,
  input wire logic mode_sel_bit0,
  input wire logic mode_sel_bit1,
  input wire logic mode_sel_bit2,
  input wire logic [7:0] cfg_byte_in,
  output logic [7:0] cfg_byte_out,
  output logic [7:0] cfg_byte_oe,
  input wire logic store_n,
  input wire logic port_sel_n,
  input wire logic busy_chain_in,
  output logic busy_chain_out,
  output logic busy_chain_oe,
  output logic done_out,
  output logic done_oe,
  input wire logic clear_n_in,
  output logic clear_n_out,
  output logic clear_n_oe
);
  localparam int UIO_W_L = cfg_port_pkg::UIO_W;
  logic [3:0] pin_m_r, pin_s_r;
  logic [UIO_W_L-1:0] uin_m_r, uin_s_r;
  cfg_port_pkg::cfg_state_t state_r, state_nxt;
  logic [cfg_port_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic [cfg_port_pkg::LEN_W-1:0] len_r, len_nxt, cnt_r, cnt_nxt;
  logic [7:0] last_r, last_nxt;
  logic keep_r, keep_nxt, od_r, od_nxt, done_r, done_nxt;
  logic [UIO_W_L-1:0] uout_r, uout_nxt, uoe_r, uoe_nxt;
  logic clk_r, clk_nxt;
  logic [cfg_port_pkg::TMR_W-1:0] div_r, div_nxt;
  logic mode_ok, leader, parallel, serial, restart, wr, rd, hit;
  logic ser_go, par_go, launch, hs_busy, hs_valid;
  logic [7:0] hs_data;
  logic [3:0] lnk_m_r, lnk_s_r;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt, word;
  logic chain_r, chain_nxt;

  // ============================================================
  // pin synchronisers into pclk: restart and mode pins, user inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_r <= 4'hf;
      pin_s_r <= 4'hf;
      uin_m_r <= cfg_port_pkg::UIO_RESET;
      uin_s_r <= cfg_port_pkg::UIO_RESET;
    end else begin
      pin_m_r <= {restart_n, mode_sel_bit2, mode_sel_bit1, mode_sel_bit0};
      pin_s_r <= pin_m_r;
      uin_m_r <= {clear_n_in, busy_chain_in, cfg_byte_in};
      uin_s_r <= uin_s_r == uin_m_r ? uin_s_r : uin_m_r;
    end
  end

  assign leader = mode_r == cfg_port_pkg::MODE_LEADER;
  assign parallel = mode_r == cfg_port_pkg::MODE_PARALLEL;
  assign serial = leader || mode_r == cfg_port_pkg::MODE_FOLLOWER;
  assign mode_ok = serial || parallel;

  // ============================================================
  // apb slave: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  always_comb begin
    hit = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      cfg_port_pkg::ADDR_CTRL: prdata = {30'h0, od_r, keep_r};
      cfg_port_pkg::ADDR_LEN: prdata = {16'h0, len_r};
      cfg_port_pkg::ADDR_STATUS:
        prdata = {23'h0, !mode_ok, done_r, state_r == cfg_port_pkg::ST_CLEAR,
                  hs_busy, mode_r, state_r};
      cfg_port_pkg::ADDR_COUNT: prdata = {16'h0, cnt_r};
      cfg_port_pkg::ADDR_LAST: prdata = {24'h0, last_r};
      cfg_port_pkg::ADDR_USER_OUT: prdata = {22'h0, uout_r};
      cfg_port_pkg::ADDR_USER_OE: prdata = {22'h0, uoe_r};
      cfg_port_pkg::ADDR_USER_IN: prdata = {22'h0, uin_s_r};
      default: hit = 1'b0;
    endcase
    if (!rd) begin
      prdata = 32'h0000_0000;
    end
  end
  assign pslverr = psel && penable && !hit;

  // ============================================================
  // configuration sequence and registers
  assign restart = !pin_s_r[3] || (wr && paddr == cfg_port_pkg::ADDR_CTRL &&
                   pwdata[cfg_port_pkg::CTRL_RESTART]);
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    last_nxt = last_r;
    done_nxt = done_r;
    len_nxt = len_r;
    keep_nxt = keep_r;
    od_nxt = od_r;
    uout_nxt = uout_r;
    uoe_nxt = uoe_r;
    unique case (state_r)
      cfg_port_pkg::ST_CLEAR: begin
        mode_nxt = pin_s_r[2:0];
        cnt_nxt = '0;
        done_nxt = 1'b0;
        if (tmr_r == cfg_port_pkg::TMR_W'(cfg_port_pkg::CLEAR_CYC - 1)) begin
          state_nxt = cfg_port_pkg::ST_LOAD;
          tmr_nxt = '0;
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
      end
      cfg_port_pkg::ST_LOAD: begin
        if (hs_valid) begin
          cnt_nxt = cnt_r + 1'b1;
          last_nxt = hs_data;
        end
        if (mode_ok && cnt_nxt >= len_r) begin
          state_nxt = cfg_port_pkg::ST_START;
          done_nxt = 1'b1;
        end
      end
      cfg_port_pkg::ST_START: begin
        if (tmr_r == cfg_port_pkg::TMR_W'(cfg_port_pkg::STARTUP_CYC - 1)) begin
          state_nxt = cfg_port_pkg::ST_USER;
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
      end
      cfg_port_pkg::ST_USER: begin
      end
    endcase
    if (wr) begin
      unique case (paddr)
        cfg_port_pkg::ADDR_CTRL: begin
          keep_nxt = pwdata[cfg_port_pkg::CTRL_KEEP];
          od_nxt = pwdata[cfg_port_pkg::CTRL_DONE_OD];
        end
        cfg_port_pkg::ADDR_LEN: len_nxt = pwdata[cfg_port_pkg::LEN_W-1:0];
        cfg_port_pkg::ADDR_USER_OUT: uout_nxt = pwdata[UIO_W_L-1:0];
        cfg_port_pkg::ADDR_USER_OE: uoe_nxt = pwdata[UIO_W_L-1:0];
        default: ;
      endcase
    end
    if (restart) begin
      state_nxt = cfg_port_pkg::ST_CLEAR;
      tmr_nxt = '0;
      done_nxt = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cfg_port_pkg::ST_CLEAR;
      tmr_r <= '0;
      mode_r <= cfg_port_pkg::MODE_FOLLOWER;
      cnt_r <= '0;
      last_r <= 8'h00;
      done_r <= 1'b0;
      len_r <= cfg_port_pkg::LEN_RESET;
      keep_r <= 1'b0;
      od_r <= 1'b0;
      uout_r <= cfg_port_pkg::UIO_RESET;
      uoe_r <= cfg_port_pkg::UIO_RESET;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      last_r <= last_nxt;
      done_r <= done_nxt;
      len_r <= len_nxt;
      keep_r <= keep_nxt;
      od_r <= od_nxt;
      uout_r <= uout_nxt;
      uoe_r <= uoe_nxt;
    end
  end

  // ============================================================
  // leader clock divider; only runs while loading in leader mode
  always_comb begin
    clk_nxt = 1'b0;
    div_nxt = '0;
    if (state_r == cfg_port_pkg::ST_LOAD && leader) begin
      clk_nxt = clk_r;
      div_nxt = div_r + 1'b1;
      if (div_r ==
          cfg_port_pkg::TMR_W'(cfg_port_pkg::LEADER_HALF_CYC - 1)) begin
        clk_nxt = !clk_r;
        div_nxt = '0;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_r <= 1'b0;
      div_r <= '0;
    end else begin
      clk_r <= clk_nxt;
      div_r <= div_nxt;
    end
  end
  // the driven clock comes back on cfg_clock through the pin
  assign cfg_clock_out = clk_r;
  assign cfg_clock_oe = state_r == cfg_port_pkg::ST_LOAD && leader;

  // ============================================================
  // link domain: enable and mode arrive as levels, stable before enable
  always_ff @(posedge cfg_clock or negedge presetn) begin
    if (!presetn) begin
      lnk_m_r <= 4'h0;
      lnk_s_r <= 4'h0;
    end else begin
      lnk_m_r <= {state_r == cfg_port_pkg::ST_LOAD && mode_ok, mode_r};
      lnk_s_r <= lnk_m_r;
    end
  end
  assign ser_go = lnk_s_r[3] && lnk_s_r[2:0] != cfg_port_pkg::MODE_PARALLEL;
  // loader holds each byte and strobes only while busy is low
  assign par_go = lnk_s_r[3] && lnk_s_r[2:0] == cfg_port_pkg::MODE_PARALLEL &&
                  !port_sel_n && !store_n && !hs_busy;
  assign word = {shift_r[6:0], cfg_byte_in[0]};
  always_comb begin
    shift_nxt = shift_r;
    bit_cnt_nxt = '0;
    chain_nxt = 1'b0;
    if (ser_go) begin
      shift_nxt = word;
      bit_cnt_nxt = bit_cnt_r + 1'b1;
      chain_nxt = cfg_byte_in[0];
    end
  end
  assign launch = par_go || (ser_go && bit_cnt_r == 3'h7);
  always_ff @(posedge cfg_clock or negedge presetn) begin
    if (!presetn) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      chain_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      chain_r <= chain_nxt;
    end
  end

  word_toggle_cdc u_cdc (
    .src_clk(cfg_clock),
    .dst_clk(pclk),
    .presetn(presetn),
    .launch(launch),
    .src_data(par_go ? cfg_byte_in : word),
    .busy(hs_busy),
    .dst_valid(hs_valid),
    .dst_data(hs_data)
  );

  // ============================================================
  // pin drivers: configuration use first, user I/O afterwards
  always_comb begin
    cfg_byte_out = 8'h00;
    cfg_byte_oe = 8'h00;
    busy_chain_out = 1'b0;
    busy_chain_oe = 1'b0;
    clear_n_out = 1'b0;
    clear_n_oe = 1'b0;
    unique case (state_r)
      cfg_port_pkg::ST_CLEAR: clear_n_oe = 1'b1;
      cfg_port_pkg::ST_LOAD, cfg_port_pkg::ST_START: begin
        busy_chain_oe = mode_ok;
        busy_chain_out = parallel ? hs_busy : chain_r;
      end
      cfg_port_pkg::ST_USER: begin
        clear_n_out = uout_r[cfg_port_pkg::UIO_INIT];
        clear_n_oe = uoe_r[cfg_port_pkg::UIO_INIT];
        if (parallel && keep_r) begin
          busy_chain_oe = 1'b1;
          busy_chain_out = hs_busy;
        end else begin
          cfg_byte_out = uout_r[7:0];
          cfg_byte_oe = uoe_r[7:0];
          busy_chain_out = uout_r[cfg_port_pkg::UIO_BUSY];
          busy_chain_oe = uoe_r[cfg_port_pkg::UIO_BUSY];
        end
      end
    endcase
  end
  // open-drain option: only ever pulls low, pull-up raises it
  assign done_out = od_r ? 1'b0 : done_r;
  assign done_oe = od_r ? !done_r : 1'b1;

  // ============================================================
  // checks
  clear_init_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == cfg_port_pkg::ST_CLEAR |-> clear_n_oe && !clear_n_out)
    else $error("clear-status pin not low while clearing");
  restart_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_s_r[3] |=> state_r == cfg_port_pkg::ST_CLEAR && !done_r)
    else $error("restart did not start a new sequence");
  leader_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_clock_oe |-> state_r == cfg_port_pkg::ST_LOAD && leader)
    else $error("clock pin driven outside leader load");
  clk_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == cfg_port_pkg::ST_USER |-> !cfg_clock_oe [*8])
    else $error("clock pin driven after configuration");
  done_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == cfg_port_pkg::ST_LOAD ##1 state_r == cfg_port_pkg::ST_START
    |-> done_r throughout (state_r == cfg_port_pkg::ST_START [*8]))
    else $error("done dropped during start-up");
  par_take_a: assert property (@(posedge cfg_clock) disable iff (!presetn)
    par_go |=> hs_busy)
    else $error("byte taken without raising busy");
  busy_free_a: assert property (@(posedge cfg_clock) disable iff (!presetn)
    $rose(hs_busy) |-> ##[1:8] !hs_busy)
    else $error("busy stuck high");
  ser_count_a: assert property (@(posedge cfg_clock) disable iff (!presetn)
    ser_go |=> bit_cnt_r == 3'($past(bit_cnt_r) + 1'b1))
    else $error("serial bit not counted");
  chain_fwd_a: assert property (@(posedge cfg_clock) disable iff (!presetn)
    ser_go |=> chain_r == $past(cfg_byte_in[0]))
    else $error("chain output not forwarding the stream");
  user_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == cfg_port_pkg::ST_USER && !keep_r |-> cfg_byte_oe == uoe_r[7:0])
    else $error("byte pins not released to user I/O");
endmodule : fpga_config_port
`default_nettype wire

// ===== test/cfg_loader_model.sv
// loader on the far side of the config port: link clock, byte bus, strobes
// assumes: bench resolves pins; lead high when the port drives the clock
`timescale 1ns/100ps
`default_nettype none
module cfg_loader_model (
  input wire logic clk_pin,
  input wire logic busy_pin,
  input wire logic lead,
  output logic clk_drv,
  output logic [7:0] byte_drv,
  output logic store_n,
  output logic port_sel_n
);
  // ============================================================
  // link clock stands still between frames
  initial begin
    clk_drv = 1'b0;
    byte_drv = 8'h00;
    store_n = 1'b1;
    port_sel_n = 1'b1;
  end
  // follower: data moves while the clock is low, away from the rising edge; leader: 1 ns after the rising edge
  task automatic tick();
    if (lead) begin
      @(posedge clk_pin);
      #1;
    end else begin
      #31;
      clk_drv = 1'b1;
      #62.5;
      clk_drv = 1'b0;
      #31.5;
    end
  endtask : tick
  // ============================================================
  // byte transfers
  task automatic send_par(input logic [7:0] b);
    int n;
    n = 0;
    while (busy_pin !== 1'b0 && n < 32) begin
      tick();
      n++;
    end
    byte_drv = b;
    port_sel_n = 1'b0;
    store_n = 1'b0;
    tick();
    store_n = 1'b1;
    port_sel_n = 1'b1;
    byte_drv = ~b;
    tick();
  endtask : send_par
  task automatic send_ser(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      byte_drv[0] = b[i];
      tick();
    end
    byte_drv[0] = ~b[0];
  endtask : send_ser
endmodule : cfg_loader_model
`default_nettype wire

// ===== test/tb_fpga_config_port.sv
// testbench of the config port: apb master, loader model, pin resolution
// assumes: zero-wait apb slave; link-side pins resolved with pull-ups
`timescale 1ns/100ps
`default_nettype none
module tb_fpga_config_port;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, restart_n;
  logic [7:0] paddr, cfg_byte_out, cfg_byte_oe;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0] mode;
  logic cfg_clock_out, cfg_clock_oe, busy_chain_out, busy_chain_oe;
  logic done_out, done_oe, clear_n_out, clear_n_oe, errv, lead;
  logic chk_en, chk_arm, prev_din;
  wire logic cfg_clock, busy_chain_in, clear_n_in, ld_clk, store_n;
  wire logic port_sel_n, mode_sel_bit0, mode_sel_bit1, mode_sel_bit2;
  wire logic [7:0] cfg_byte_in, ld_byte;
  int checks, mismatches;
  logic [7:0] pb [4] = '{8'h3c, 8'h00, 8'hff, 8'h5a};
  // ============================================================
  // pins: owner drives when enabled, loader or pull-up otherwise
  assign {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} = mode;
  assign cfg_clock = cfg_clock_oe ? cfg_clock_out : ld_clk;
  assign cfg_byte_in = (cfg_byte_oe & cfg_byte_out) | (~cfg_byte_oe & ld_byte);
  assign busy_chain_in = busy_chain_oe ? busy_chain_out : 1'b1;
  assign clear_n_in = clear_n_oe ? clear_n_out : 1'b1;
  fpga_config_port i_fpga_config_port (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .cfg_clock, .cfg_clock_out, .cfg_clock_oe,
    .restart_n, .mode_sel_bit0, .mode_sel_bit1, .mode_sel_bit2,
    .cfg_byte_in, .cfg_byte_out, .cfg_byte_oe, .store_n, .port_sel_n,
    .busy_chain_in, .busy_chain_out, .busy_chain_oe, .done_out, .done_oe,
    .clear_n_in, .clear_n_out, .clear_n_oe
  );
  cfg_loader_model i_cfg_loader_model (
    .clk_pin(cfg_clock), .busy_pin(busy_chain_in), .lead(lead),
    .clk_drv(ld_clk), .byte_drv(ld_byte), .store_n(store_n),
    .port_sel_n(port_sel_n)
  );
  always #4 pclk = ~pclk;
  // ============================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) mismatches++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write settle before anyone looks at the pins
    @(negedge pclk);
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdv & m, exp);
  endtask : rd_chk
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, cfg_port_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (rdv[1:0] !== s && n < 400);
    check(32'(rdv[1:0]), 32'(s));
  endtask : wait_state
  task automatic restart(input logic [2:0] m);
    @(posedge pclk);
    mode <= m;
    restart_n <= 1'b0;
    repeat (4) @(posedge pclk);
    restart_n <= 1'b1;
  endtask : restart
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // chain output repeats the bit taken one link edge before
  always @(posedge cfg_clock) begin
    if (chk_en) begin
      if (chk_arm) check(32'(busy_chain_out), 32'(prev_din));
      prev_din = cfg_byte_in[0];
      chk_arm = 1'b1;
    end else begin
      chk_arm = 1'b0;
    end
  end
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
  // ============================================================
  // tests
  initial begin
    {pclk, presetn, psel, penable, pwrite, lead, chk_en, chk_arm} = '0;
    {paddr, pwdata, prev_din} = '0;
    restart_n = 1'b1;
    mode = cfg_port_pkg::MODE_PARALLEL;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'({clear_n_oe, clear_n_out}), 32'h2);
    rd_chk(cfg_port_pkg::ADDR_STATUS, 32'hc3, 32'h40);
    rd_chk(cfg_port_pkg::ADDR_LEN, 32'hffff, 32'(cfg_port_pkg::LEN_RESET));
    apb(1'b0, 8'h20, 32'h0);
    check({errv, rdv[30:0]}, 32'h80000000);
    // parallel load of four bytes
    apb(1'b1, cfg_port_pkg::ADDR_LEN, 32'h4);
    wait_state(2'h1);
    check(32'(cfg_clock_oe), 32'h0);
    rd_chk(cfg_port_pkg::ADDR_STATUS, 32'h1c, 32'h18);
    repeat (3) i_cfg_loader_model.tick();
    foreach (pb[i]) i_cfg_loader_model.send_par(pb[i]);
    wait_state(2'h2);
    check(32'(done_out), 32'h1);
    wait_state(2'h3);
    rd_chk(cfg_port_pkg::ADDR_COUNT, 32'hffff, 32'h4);
    rd_chk(cfg_port_pkg::ADDR_LAST, 32'hff, 32'h5a);
    check(32'({done_out, clear_n_oe}), 32'h2);
    apb(1'b1, cfg_port_pkg::ADDR_USER_OE, 32'hff);
    apb(1'b1, cfg_port_pkg::ADDR_USER_OUT, 32'ha5);
    check(32'({cfg_byte_oe, cfg_byte_out}), 32'hffa5);
    rd_chk(cfg_port_pkg::ADDR_USER_IN, 32'hff, 32'ha5);
    // follower serial load, done open-drain, restart by pin
    apb(1'b1, cfg_port_pkg::ADDR_USER_OE, 32'h0);
    apb(1'b1, cfg_port_pkg::ADDR_LEN, 32'h2);
    apb(1'b1, cfg_port_pkg::ADDR_CTRL, 32'h2);
    restart(cfg_port_pkg::MODE_FOLLOWER);
    wait_state(2'h0);
    check(32'({done_oe, done_out, clear_n_oe, clear_n_out}), 32'ha);
    wait_state(2'h1);
    check(32'({busy_chain_oe, cfg_clock_oe}), 32'h2);
    // two edges carry the load enable across; the third takes a bit
    repeat (2) i_cfg_loader_model.tick();
    chk_en = 1'b1;
    i_cfg_loader_model.send_ser(8'hc3);
    i_cfg_loader_model.send_ser(8'h96);
    chk_en = 1'b0;
    // flush the stale enable out of the link side before leader mode
    repeat (2) i_cfg_loader_model.tick();
    wait_state(2'h3);
    rd_chk(cfg_port_pkg::ADDR_LAST, 32'hff, 32'h96);
    check(32'({done_oe, done_out}), 32'h0);
    apb(1'b1, cfg_port_pkg::ADDR_USER_OE, 32'h100);
    apb(1'b1, cfg_port_pkg::ADDR_USER_OUT, 32'h100);
    check(32'({busy_chain_oe, busy_chain_out}), 32'h3);
    // leader serial load: the port drives the link clock
    apb(1'b1, cfg_port_pkg::ADDR_USER_OE, 32'h0);
    lead = 1'b1;
    restart(cfg_port_pkg::MODE_LEADER);
    wait_state(2'h1);
    check(32'(cfg_clock_oe), 32'h1);
    repeat (2) i_cfg_loader_model.tick();
    chk_en = 1'b1;
    i_cfg_loader_model.send_ser(8'h81);
    i_cfg_loader_model.send_ser(8'h7e);
    chk_en = 1'b0;
    wait_state(2'h3);
    rd_chk(cfg_port_pkg::ADDR_LAST, 32'hff, 32'h7e);
    check(32'(cfg_clock_oe), 32'h0);
    end_sim();
  end
endmodule : tb_fpga_config_port
`default_nettype wire
